// ===== core/ibs_core.sv
// Interrupt enables, slave, line and master flags and master bus status for the two-wire unit.
// Assumes synchronous line inputs and master/slave engine event pulses.
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
`default_nettype none

module ibs_core #(
  parameter int TIMEOUT_CYC = ibs_pkg::TIMEOUT_CYC
) (
  input  wire logic          ref_clk,
  input  wire logic          srst,
  input  wire ibs_pkg::ibs_req_s req,
  output logic [7:0]         rd_data,
  input  wire logic          sda_in,
  input  wire logic          scl_in,
  output logic               sda_out,
  output logic               sda_oe,
  input  wire ibs_pkg::ibs_mst_s mst,
  input  wire ibs_pkg::ibs_slv_s slv,
  output logic               irq
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam int TW = $clog2(TIMEOUT_CYC + 1);

  ibs_pkg::ibs_line_s lev;
  ibs_pkg::ibs_bs_e   bs_reg;
  ibs_pkg::ibs_bs_e   bs_next;
  logic [7:0]         ien_reg;
  logic [7:0]         flags_reg;
  logic               arb_reg;
  logic               berr_reg;
  logic               nack_reg;
  logic               ack_action_reg;
  logic [7:0]         maddr_reg;
  logic               sync_busy_reg;
  logic [3:0]         sync_cnt_reg;
  logic [TW-1:0]      to_cnt_reg;
  logic               ack_rise_reg;
  logic [7:0]         status_w;
  logic               maddr_wr;
  logic               sync_done;
  logic               to_ev;
  logic               berr_ev;
  logic               arb_ev;
  logic               idle_wr;
  logic               arb_clr_w;
  logic [7:0]         flag_set;

  function automatic logic hit(input ibs_pkg::ibs_req_s r, input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  function automatic logic [7:0] wmask(input ibs_pkg::ibs_req_s r, input logic [7:0] ofs,
                                       input logic [7:0] m);
    return hit(r, ofs) ? (r.wdata & m) : 8'h00;
  endfunction

  ibs_line_mon u_mon (
    .ref_clk (ref_clk),
    .srst    (srst),
    .sda_in  (sda_in),
    .scl_in  (scl_in),
    .evt     (lev)
  );

  // ****************************************
  // Events
  // ****************************************
  assign maddr_wr  = hit(req, ibs_pkg::OFS_MADDR);
  assign idle_wr   = hit(req, ibs_pkg::OFS_STATUS) &&
                     (req.wdata[ibs_pkg::ST_BS_LO +: 2] == ibs_pkg::BS_IDLE);
  assign arb_clr_w = hit(req, ibs_pkg::OFS_STATUS) && req.wdata[ibs_pkg::ST_ARB];
  assign sync_done = sync_busy_reg && (sync_cnt_reg == 4'h1);
  assign to_ev     = lev.in_frame && (to_cnt_reg == TW'(TIMEOUT_CYC - 1));
  assign berr_ev   = lev.err | to_ev;
  assign arb_ev    = (bs_reg == ibs_pkg::BS_OWNER) &&
                     ((mst.tx_high && lev.scl_rise && !lev.sda_hi) || berr_ev);

  assign status_w = {2'b00, bs_reg, 1'b0, nack_reg, arb_reg, berr_reg};

  // ****************************************
  // Interrupt enables
  // ****************************************
  // One enable store serves both the set and clear views
  always_ff @(posedge ref_clk) begin
    if (srst)
      ien_reg <= ibs_pkg::RESET_BYTE;
    else
      ien_reg <= (ien_reg | wmask(req, ibs_pkg::OFS_IEN_SET, ibs_pkg::IEN_MASK))
                 & ~wmask(req, ibs_pkg::OFS_IEN_CLR, ibs_pkg::IEN_MASK);
  end

  // ****************************************
  // Interrupt flags
  // ****************************************
  always_comb begin
    flag_set                   = 8'h00;
    flag_set[ibs_pkg::IE_ERR]  = berr_ev;
    flag_set[ibs_pkg::IE_DATA_READY] = slv.data_done;
    flag_set[ibs_pkg::IE_AM]   = slv.addr_match;
    flag_set[ibs_pkg::IE_STOP_RECEIVED] = lev.stop;
    flag_set[ibs_pkg::FL_MB]   = arb_ev;
  end

  // A new event in the cycle of a clear survives it
  always_ff @(posedge ref_clk) begin
    if (srst)
      flags_reg <= ibs_pkg::RESET_BYTE;
    else
      flags_reg <= (flags_reg & ~wmask(req, ibs_pkg::OFS_FLAGS, ibs_pkg::FLAG_MASK))
                   | flag_set;
  end

  always_ff @(posedge ref_clk) begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |(flags_reg & ien_reg & ibs_pkg::IEN_MASK);
  end

  // ****************************************
  // Status bits
  // ****************************************
  // These act on the write cycle itself, no sync handshake
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      arb_reg  <= 1'b0;
      berr_reg <= 1'b0;
    end else begin
      arb_reg  <= (arb_reg & ~(maddr_wr | arb_clr_w)) | arb_ev;
      berr_reg <= (berr_reg & ~maddr_wr) | berr_ev;
    end
  end

  // Software writes never reach this bit
  always_ff @(posedge ref_clk) begin
    if (srst)
      nack_reg <= 1'b0;
    else if (mst.ack_slot && lev.scl_rise)
      nack_reg <= lev.sda_hi;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      maddr_reg  <= ibs_pkg::RESET_BYTE;
      ack_action_reg <= 1'b0;
    end else begin
      if (maddr_wr)
        maddr_reg <= req.wdata;
      if (hit(req, ibs_pkg::OFS_CTRL))
        ack_action_reg <= req.wdata[ibs_pkg::CT_ACK_ACTION];
    end
  end

  // ****************************************
  // Bus state synchronisation
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync_busy_reg <= 1'b0;
      sync_cnt_reg  <= 4'h0;
    end else if (idle_wr) begin
      sync_busy_reg <= 1'b1;
      sync_cnt_reg  <= 4'(ibs_pkg::SYNC_CYC);
    end else if (sync_busy_reg) begin
      sync_cnt_reg <= sync_cnt_reg - 4'h1;
      if (sync_done)
        sync_busy_reg <= 1'b0;
    end
  end

  // ****************************************
  // Bus state machine
  // ****************************************
  // Codes are fixed by software view, so the path is not fully Gray
  always_comb begin
    bs_next = bs_reg;
    case (bs_reg)
      ibs_pkg::BS_UNKNOWN: begin
        if (lev.stop || sync_done)
          bs_next = ibs_pkg::BS_IDLE;
      end
      ibs_pkg::BS_IDLE: begin
        if (mst.start)
          bs_next = ibs_pkg::BS_OWNER;
        else if (lev.start)
          bs_next = ibs_pkg::BS_BUSY;
      end
      ibs_pkg::BS_OWNER: begin
        if (lev.stop || to_ev)
          bs_next = ibs_pkg::BS_IDLE;
        else if (arb_ev)
          bs_next = ibs_pkg::BS_BUSY;
      end
      ibs_pkg::BS_BUSY: begin
        if (lev.stop || to_ev)
          bs_next = ibs_pkg::BS_IDLE;
      end
      default: bs_next = ibs_pkg::BS_UNKNOWN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst)
      bs_reg <= ibs_pkg::BS_UNKNOWN;
    else
      bs_reg <= bs_next;
  end

  // ****************************************
  // Frame time-out
  // ****************************************
  // Any clock edge restarts the count; idle lines outside a frame never time out
  always_ff @(posedge ref_clk) begin
    if (srst)
      to_cnt_reg <= '0;
    else if (!lev.in_frame || lev.scl_rise || lev.scl_fall || to_ev)
      to_cnt_reg <= '0;
    else
      to_cnt_reg <= to_cnt_reg + TW'(1);
  end

  // ****************************************
  // Slave acknowledge drive
  // ****************************************
  // Held from the match through the ack clock, released on its falling edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sda_oe       <= 1'b0;
      sda_out      <= 1'b0;
      ack_rise_reg <= 1'b0;
    end else if (slv.addr_match) begin
      sda_oe       <= ~ack_action_reg;
      ack_rise_reg <= 1'b0;
    end else if (sda_oe) begin
      if (lev.scl_rise)
        ack_rise_reg <= 1'b1;
      if (lev.scl_fall && ack_rise_reg)
        sda_oe <= 1'b0;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_data <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        ibs_pkg::OFS_CTRL:    rd_data <= {7'h00, ack_action_reg};
        ibs_pkg::OFS_IEN_SET: rd_data <= ien_reg;
        ibs_pkg::OFS_IEN_CLR: rd_data <= ien_reg;
        ibs_pkg::OFS_FLAGS:   rd_data <= flags_reg;
        ibs_pkg::OFS_STATUS:  rd_data <= status_w;
        ibs_pkg::OFS_SYNCB:   rd_data <= {7'h00, sync_busy_reg};
        ibs_pkg::OFS_MADDR:   rd_data <= maddr_reg;
        default:              rd_data <= 8'h00;
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_idle_wr;
    idle_wr && !sync_busy_reg;
  endsequence

  sequence s_busy_run;
    sync_busy_reg [*3];
  endsequence

  ien_clr_a: assert property (hit(req, ibs_pkg::OFS_IEN_CLR) && req.wdata[ibs_pkg::IE_ERR]
    |=> !ien_reg[ibs_pkg::IE_ERR])
    else $error("error enable not cleared");

  ien_zero_a: assert property (hit(req, ibs_pkg::OFS_IEN_CLR) && req.wdata == 8'h00
    |=> ien_reg == $past(ien_reg))
    else $error("zero clear write changed enables");

  ien_set_a: assert property (hit(req, ibs_pkg::OFS_IEN_SET) && req.wdata[ibs_pkg::IE_DATA_READY]
    |=> ien_reg[ibs_pkg::IE_DATA_READY])
    else $error("set write did not enable");

  bs_hold_a: assert property (bs_reg == ibs_pkg::BS_UNKNOWN && !lev.stop && !sync_done
    |=> bs_reg == ibs_pkg::BS_UNKNOWN)
    else $error("unknown state left without cause");

  sync_busy_a: assert property (s_idle_wr |=> s_busy_run ##1 !sync_busy_reg)
    else $error("sync busy timing wrong");

  nack_ro_a: assert property (hit(req, ibs_pkg::OFS_STATUS) && !mst.ack_slot
    |=> nack_reg == $past(nack_reg))
    else $error("nack bit changed by write");

  arb_mb_a: assert property (arb_ev |=> arb_reg && flags_reg[ibs_pkg::FL_MB])
    else $error("arbitration loss not flagged");

  berr_own_a: assert property (berr_ev && bs_reg == ibs_pkg::BS_OWNER
    |=> berr_reg && arb_reg)
    else $error("owner bus error incomplete");

  berr_clr_a: assert property (maddr_wr && !berr_ev |=> !berr_reg)
    else $error("address write kept bus error");

  irq_out_a: assert property (|(flags_reg & ien_reg & ibs_pkg::IEN_MASK) |=> irq)
    else $error("irq missing");

  address_match_ack_a: assert property (slv.addr_match && !ack_action_reg
    |=> sda_oe && flags_reg[ibs_pkg::IE_AM])
    else $error("address match ack missing");

endmodule // ibs_core

`default_nettype wire

// ===== core/ibs_pkg.sv
// Constants, types and register map for the two-wire irq-enable and bus-status block.
// Assumes a single 250 MHz clock and a plain single-cycle register port.

package ibs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_IEN_SET = 8'h10;
  localparam logic [7:0] OFS_IEN_CLR = 8'h14;
  localparam logic [7:0] OFS_FLAGS   = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1C;
  localparam logic [7:0] OFS_SYNCB   = 8'h20;
  localparam logic [7:0] OFS_MADDR   = 8'h24;

  localparam int IE_ERR    = 7;
  localparam int IE_DATA_READY   = 2;
  localparam int IE_AM     = 1;
  localparam int IE_STOP_RECEIVED   = 0;
  localparam int FL_MB     = 3;
  localparam int ST_BUS_ERROR = 0;
  localparam int ST_ARB    = 1;
  localparam int ST_NACK   = 2;
  localparam int ST_BS_LO  = 4;
  localparam int SB_SYSTEM_OP_SYNC  = 0;
  localparam int CT_ACK_ACTION = 0;

  localparam logic [7:0] IEN_MASK   = 8'h87;
  localparam logic [7:0] FLAG_MASK  = 8'h8F;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ****************************************
  // Bus state
  // ****************************************
  typedef enum logic [1:0] {
    BS_UNKNOWN = 2'h0,
    BS_IDLE    = 2'h1,
    BS_OWNER   = 2'h2,
    BS_BUSY    = 2'h3
  } ibs_bs_e;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS      = 4;
  localparam int SYNC_NS     = 12;
  localparam int SYNC_CYC    = (SYNC_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMEOUT_US  = 1000;
  localparam int TIMEOUT_CYC = TIMEOUT_US * 1000 / CLK_NS;
  localparam int BITS_BYTE   = 9;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ibs_req_s;

  typedef struct packed {
    logic start;
    logic tx_high;
    logic ack_slot;
  } ibs_mst_s;

  typedef struct packed {
    logic data_done;
    logic addr_match;
  } ibs_slv_s;

  typedef struct packed {
    logic start;
    logic stop;
    logic err;
    logic scl_rise;
    logic scl_fall;
    logic sda_hi;
    logic in_frame;
  } ibs_line_s;

endpackage

// ===== core/ibs_line_mon.sv
// Watches the two-wire lines and reports start, stop, edges and protocol faults.
// Assumes the line inputs are already synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none

module ibs_line_mon (
  input  wire logic          ref_clk,
  input  wire logic          srst,
  input  wire logic          sda_in,
  input  wire logic          scl_in,
  output ibs_pkg::ibs_line_s evt
);

  logic       sda_q;
  logic       scl_q;
  logic [3:0] bit_cnt_reg;
  logic       frame_reg;
  logic       start_w;
  logic       stop_w;

  assign start_w = sda_q & ~sda_in & scl_q & scl_in;
  assign stop_w  = ~sda_q & sda_in & scl_q & scl_in;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sda_q <= 1'b1;
      scl_q <= 1'b1;
    end else begin
      sda_q <= sda_in;
      scl_q <= scl_in;
    end
  end

  // A legal condition only sits right after the first rise of a byte
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bit_cnt_reg <= 4'h0;
      frame_reg   <= 1'b0;
    end else if (start_w) begin
      bit_cnt_reg <= 4'h0;
      frame_reg   <= 1'b1;
    end else if (stop_w) begin
      frame_reg <= 1'b0;
    end else if (frame_reg && scl_in && !scl_q) begin
      if (bit_cnt_reg == 4'(ibs_pkg::BITS_BYTE - 1))
        bit_cnt_reg <= 4'h0;
      else
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      evt <= '0;
    end else begin
      evt.start    <= start_w;
      evt.stop     <= stop_w;
      evt.err      <= (start_w | stop_w) & frame_reg & (bit_cnt_reg != 4'h1);
      evt.scl_rise <= scl_in & ~scl_q;
      evt.scl_fall <= ~scl_in & scl_q;
      evt.sda_hi   <= sda_in;
      evt.in_frame <= frame_reg;
    end
  end

endmodule // ibs_line_mon

`default_nettype wire

// ===== dv/ibs_bus_peer.sv
// Behavioural peer on the shared two-wire lines: another master or slave.
// Assumes the bench resolves open-drain levels, with pull-ups on both lines.
`timescale 1ns/1ns
`default_nettype none

module ibs_bus_peer (
  input  wire logic ref_clk,
  output logic      sda_o,
  output logic      scl_o
);
  // Cycles per line step; raise it for a slow peer
  int hold = 3;

  // High means released, so the pull-up wins
  initial begin
    sda_o = 1'b1;
    scl_o = 1'b1;
  end

  // ****************************************
  // Line steps
  // ****************************************
  // One line change per step, so no edge is seen out of order
  task automatic step(input logic sda, input logic scl);
    sda_o <= sda;
    scl_o <= scl;
    repeat (hold) @(posedge ref_clk);
  endtask

  task automatic start_cond();
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask

  task automatic stop_cond();
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
  endtask
endmodule // ibs_bus_peer

`default_nettype wire

// ===== dv/i2c_irq_enable_and_bus_status_tb.sv
// Self-checking bench for the irq-enable and bus-status core.
// Assumes the peer model on the lines and a register port driven at rising edges.
`timescale 1ns/1ns
`default_nettype none

module i2c_irq_enable_and_bus_status_tb;
  // ****************************************
  // Signals and model state
  // ****************************************
  localparam int         TO_CYC = 50;
  localparam logic [7:0] A_SET  = ibs_pkg::OFS_IEN_SET;
  localparam logic [7:0] A_CLR  = ibs_pkg::OFS_IEN_CLR;
  localparam logic [7:0] A_FL   = ibs_pkg::OFS_FLAGS;
  localparam logic [7:0] A_ST   = ibs_pkg::OFS_STATUS;
  localparam logic [7:0] A_SB   = ibs_pkg::OFS_SYNCB;
  localparam logic [7:0] A_MA   = ibs_pkg::OFS_MADDR;
  localparam logic [7:0] A_CT   = ibs_pkg::OFS_CTRL;

  logic              ref_clk = 1'b0;
  logic              srst    = 1'b1;
  ibs_pkg::ibs_req_s req     = '0;
  ibs_pkg::ibs_mst_s mst     = '0;
  ibs_pkg::ibs_slv_s slv     = '0;
  logic [7:0]        rd_data;
  logic              sda_out;
  logic              sda_oe;
  logic              irq;
  logic              p_sda;
  logic              p_scl;
  int                errors;
  int                total_checks;
  int                m_ien;
  int                m_flg;
  int                ebit[4] = '{7, 2, 1, 0};
  logic [7:0]        s;
  logic [7:0]        c;

  // Open drain: either party pulling low wins
  wire logic sda_line = p_sda & ~(sda_oe & ~sda_out);

  always #2 ref_clk = ~ref_clk;

  ibs_bus_peer peer (.ref_clk(ref_clk), .sda_o(p_sda), .scl_o(p_scl));

  ibs_core #(.TIMEOUT_CYC(TO_CYC)) dut (
    .ref_clk(ref_clk), .srst(srst), .req(req), .rd_data(rd_data),
    .sda_in(sda_line), .scl_in(p_scl), .sda_out(sda_out), .sda_oe(sda_oe),
    .mst(mst), .slv(slv), .irq(irq));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test();
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req.wr <= 1'b0;
    // Let an edge pass so the next request never lands in this time step
    @(posedge ref_clk);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    @(negedge ref_clk);
    chk(rd_data & m, exp & m);
    @(posedge ref_clk);
  endtask

  // Irq lags its cause by a cycle, so allow two edges
  task automatic look(input bit pick_irq, input logic exp);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({7'h00, pick_irq ? irq : sda_oe}, {7'h00, exp});
    @(posedge ref_clk);
  endtask

  task automatic rst();
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic reinit();
    // Release both lines first so no false start follows the reset
    peer.step(1'b1, 1'b1);
    rst();
    wr(A_ST, 8'h10);
    repeat (5) @(posedge ref_clk);
    m_ien = 0;
    m_flg = 0;
  endtask

  task automatic own_start();
    mst.start <= 1'b1;
    @(posedge ref_clk);
    mst.start <= 1'b0;
  endtask

  task automatic spulse(input ibs_pkg::ibs_slv_s v);
    slv <= v;
    @(posedge ref_clk);
    slv <= '0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    finish_test();
  end

  initial begin
    void'($urandom(32'hd979));
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rd(A_CLR, 8'h00);
    rd(A_ST, 8'h00);
    peer.stop_cond();
    rd(A_ST, 8'h10);
    for (int i = 0; i < 8; i++) begin
      s = 8'($urandom);
      c = 8'($urandom);
      wr(A_SET, s);
      m_ien = (m_ien | int'(s)) & 'h87;
      rd(A_CLR, 8'(m_ien));
      wr(A_CLR, c);
      m_ien = m_ien & ~int'(c);
      rd(A_SET, 8'(m_ien));
    end
    foreach (ebit[k]) begin
      wr(A_SET, 8'h87);
      wr(A_CLR, 8'h00);
      rd(A_CLR, 8'h87);
      wr(A_CLR, 8'(1 << ebit[k]));
      rd(A_CLR, 8'(8'h87 & ~(1 << ebit[k])));
    end
    // Unmapped place: reads zero, write lost
    wr(8'h3C, 8'hFF);
    rd(8'h3C, 8'h00);
    rd(A_CLR, 8'h86);
    rst();
    wr(A_ST, 8'h20);
    rd(A_ST, 8'h00);
    wr(A_ST, 8'h10);
    rd(A_SB, 8'h01);
    repeat (4) @(posedge ref_clk);
    rd(A_SB, 8'h00);
    rd(A_ST, 8'h10);
    // Arbitration lost while sending a high bit
    reinit();
    own_start();
    rd(A_ST, 8'h20);
    mst.tx_high <= 1'b1;
    peer.step(1'b1, 1'b0);
    peer.step(1'b0, 1'b0);
    peer.step(1'b0, 1'b1);
    mst.tx_high <= 1'b0;
    m_flg = 'h08;
    rd(A_ST, 8'h32);
    rd(A_FL, 8'(m_flg), 8'h0F);
    wr(A_ST, 8'h00);
    rd(A_ST, 8'h32);
    wr(A_ST, 8'h02);
    rd(A_ST, 8'h30);
    // Start directly followed by stop
    reinit();
    peer.start_cond();
    peer.step(1'b1, 1'b1);
    m_flg = 'h01;
    rd(A_ST, 8'h11);
    rd(A_FL, 8'(m_flg), 8'h0F);
    wr(A_MA, 8'h00);
    rd(A_ST, 8'h10);
    reinit();
    own_start();
    peer.start_cond();
    peer.step(1'b1, 1'b1);
    m_flg = 'h09;
    rd(A_ST, 8'h13);
    rd(A_FL, 8'(m_flg), 8'h0F);
    wr(A_MA, 8'h5A);
    rd(A_ST, 8'h10);
    // Frame left hanging with no clock edges
    reinit();
    peer.start_cond();
    rd(A_ST, 8'h30);
    repeat (TO_CYC + 10) @(posedge ref_clk);
    rd(A_ST, 8'h11);
    peer.step(1'b1, 1'b1);
    reinit();
    mst.ack_slot <= 1'b1;
    peer.step(1'b1, 1'b0);
    peer.step(1'b1, 1'b1);
    rd(A_ST, 8'h14);
    wr(A_ST, 8'h04);
    rd(A_ST, 8'h14);
    peer.step(1'b1, 1'b0);
    peer.step(1'b0, 1'b0);
    peer.step(1'b0, 1'b1);
    rd(A_ST, 8'h10);
    mst.ack_slot <= 1'b0;
    peer.step(1'b0, 1'b0);
    peer.step(1'b1, 1'b0);
    peer.step(1'b1, 1'b1);
    // Slave side with a slow peer
    reinit();
    peer.hold = 8;
    wr(A_SET, 8'h02);
    spulse('{data_done: 1'b0, addr_match: 1'b1});
    look(1'b0, 1'b1);
    look(1'b1, 1'b1);
    rd(A_FL, 8'h02, 8'h0F);
    peer.step(1'b1, 1'b0);
    peer.step(1'b1, 1'b1);
    peer.step(1'b1, 1'b0);
    look(1'b0, 1'b0);
    peer.step(1'b1, 1'b1);
    wr(A_CLR, 8'h02);
    look(1'b1, 1'b0);
    spulse('{data_done: 1'b1, addr_match: 1'b0});
    rd(A_FL, 8'h06, 8'h0F);
    wr(A_SET, 8'h04);
    look(1'b1, 1'b1);
    wr(A_FL, 8'h06);
    look(1'b1, 1'b0);
    wr(A_CT, 8'h01);
    spulse('{data_done: 1'b0, addr_match: 1'b1});
    look(1'b0, 1'b0);
    rd(A_FL, 8'h02, 8'h0F);
    @(negedge ref_clk);
    chk({7'h00, sda_out}, 8'h00);
    finish_test();
  end
endmodule // i2c_irq_enable_and_bus_status_tb

`default_nettype wire
